/* rtl/drp_params.svh */
`ifndef DRP_PARAMS_SVH
`define DRP_PARAMS_SVH

// register byte offsets
`define DRP_OFS_DEBUG_ID 12'h000
`define DRP_OFS_EVENT_CATCH 12'h004
`define DRP_OFS_RUN_CONTROL 12'h008
`define DRP_OFS_OS_LOCK_ACCESS 12'h00C
`define DRP_OFS_OS_LOCK_STATUS 12'h010
`define DRP_OFS_OS_SAVE_RESTORE 12'h014
`define DRP_OFS_POWER_STATUS 12'h018
// core-domain register page, one word per entry from 0x100
`define DRP_CORE_PAGE 4'h1

// field positions
`define DRP_EC_OS_UNLOCK 0
`define DRP_RC_HALT 0
`define DRP_RC_RESTART 1
`define DRP_RC_CLR_STICKY 2
`define DRP_OLS_IMPL 0
`define DRP_OLS_LOCKED 1
`define DRP_PS_CORE_UP 0
`define DRP_PS_HALT_REQ 1
`define DRP_PS_HALTED 2

// values
`define DRP_OS_KEY 32'hC5ACCE55
`define DRP_RESP_OKAY 2'h0
`define DRP_RESP_SLVERR 2'h2
`define DRP_RESP_DECERR 2'h3
`define DRP_ZERO_WORD 32'h0000_0000

`endif

/* rtl/drp_pkg.sv */
`default_nettype none
package drp_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_DONE
  } drp_state_t;

  typedef enum logic [1:0] {
    SRC_COP,
    SRC_WR,
    SRC_RD
  } drp_src_t;

  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
  } drp_acc_t;

endpackage : drp_pkg
`default_nettype wire

/* rtl/drp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module drp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;

  // three stages, output moves only when stage two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          out_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  assign dout = out_reg;

endmodule : drp_sync
`default_nettype wire

/* rtl/drp_core_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module drp_core_mem #(
  parameter int WORDS = 16,
  parameter int IW = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [3:0] strb,
  input wire logic [IW-1:0] idx,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);

  logic [31:0] mem [WORDS];
  logic [31:0] rdata_reg;

  // byte-enabled write, registered read
  always_ff @(posedge aclk) begin
    if (we) begin
      for (int b = 0; b < 4; b++) begin
        if (strb[b]) begin
          mem[idx][8*b +: 8] <= wdata[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= mem[idx];
    end
  end

  assign rdata = rdata_reg;

endmodule : drp_core_mem
`default_nettype wire

/* rtl/drp_top.sv */
// Functional notes
// - core software reaches debug registers through the coprocessor request port
// - an external debugger port is always present and never omitted
// - extended coprocessor and memory-mapped paths are both built here
// - at least one of coprocessor or memory-mapped path exists; here both
// - memory-mapped path answers plain loads and stores at fixed addresses
// - memory-mapped and external debugger port is one bus slave
// - core-domain access while core is off gets slave error, no stall
// - debug-domain registers keep value and stay readable with core off
// - event catch bit lives in debug domain; core power-down never clears it
// - halt request bit survives power-down and blocked secure state
// - pending halt requests reach the core only while it is powered
// - os lock lives in debug domain and stays set across power-down
// - separate debug and core register groups allow debug over power-down
// - bus control logic and surviving registers sit in the debug domain
// - id, event catch and run control never return an error
// - writing the key to os lock access resets the sequence counter
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "drp_params.svh"
`default_nettype none
module drp_top #(
  // arbitrary identification value
  parameter logic [31:0] DEBUG_ID = 32'h0000_1001,
  parameter int CORE_WORDS = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic cop_req,
  input wire logic cop_wr,
  input wire logic [11:0] cop_addr,
  input wire logic [31:0] cop_wdata,
  output logic cop_ack,
  output logic [31:0] cop_rdata,
  output logic cop_err,
  input wire logic core_powered_up,
  input wire logic external_halt_request,
  input wire logic invasive_debug_enable,
  input wire logic secure_invasive_enable,
  input wire logic core_secure,
  input wire logic core_halted,
  output logic halt_req,
  output logic restart_req,
  output logic clear_sticky_req,
  output logic os_lock
);

  localparam int IW = $clog2(CORE_WORDS);

  // pin inputs from other domains
  logic [3:0] pin_s;
  drp_sync #(.WIDTH(4)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({secure_invasive_enable, invasive_debug_enable, external_halt_request,
          core_powered_up}),
    .dout(pin_s)
  );
  wire core_up = pin_s[0];
  wire ext_halt = pin_s[1];
  wire inv_en = pin_s[2];
  wire sec_en = pin_s[3];

  drp_pkg::drp_state_t state_reg;
  drp_pkg::drp_src_t src_reg;
  drp_pkg::drp_acc_t acc_reg;

  logic aw_held_reg, w_held_reg, ar_held_reg;
  logic [11:0] aw_addr_reg, ar_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg, rvalid_reg, cop_ack_reg, cop_err_reg;
  logic [1:0] bresp_reg, rresp_reg, resp_reg;
  logic [31:0] rdata_reg, cop_rdata_reg, rd_direct_reg;
  logic rd_mem_reg;
  logic event_catch_reg, halt_pend_reg, os_lock_reg;
  logic [IW:0] seq_cnt_reg;
  logic halt_req_reg, restart_reg, clr_sticky_reg;
  logic [31:0] mem_rdata;

  // source selection, coprocessor first
  // coprocessor path
  wire take_cop = cop_req && !cop_ack_reg;
  wire take_wr = aw_held_reg && w_held_reg && !bvalid_reg;
  wire take_rd = ar_held_reg && !rvalid_reg;
  wire take_any = take_cop || take_wr || take_rd;

  wire [11:0] a = acc_reg.addr;
  wire hit_id = a == `DRP_OFS_DEBUG_ID;
  wire hit_ec = a == `DRP_OFS_EVENT_CATCH;
  wire hit_rc = a == `DRP_OFS_RUN_CONTROL;
  wire hit_ola = a == `DRP_OFS_OS_LOCK_ACCESS;
  wire hit_ols = a == `DRP_OFS_OS_LOCK_STATUS;
  wire hit_osr = a == `DRP_OFS_OS_SAVE_RESTORE;
  wire hit_pwr = a == `DRP_OFS_POWER_STATUS;
  wire core_grp = (a[11:8] == `DRP_CORE_PAGE) && (a[1:0] == 2'h0)
                  && (32'(a[7:2]) < 32'(CORE_WORDS));
  wire mapped = hit_id || hit_ec || hit_rc || hit_ola || hit_ols || hit_osr
                || hit_pwr || core_grp;
  wire core_blocked = (core_grp || hit_osr) && !core_up;
  wire osr_blocked = hit_osr && !os_lock_reg;
  wire [1:0] err_resp = !mapped ? `DRP_RESP_DECERR :
                        (core_blocked || osr_blocked) ? `DRP_RESP_SLVERR :
                        `DRP_RESP_OKAY;
  wire ok = err_resp == `DRP_RESP_OKAY;
  wire in_exec = state_reg == drp_pkg::ST_EXEC;
  wire exec_ok = in_exec && ok;
  wire exec_wr = exec_ok && acc_reg.wr;
  wire [3:0] st = acc_reg.strb;
  wire [31:0] wd = acc_reg.wdata;

  // os save/restore sequencing
  wire seq_zero = seq_cnt_reg == '0;
  wire [IW:0] seq_m1 = seq_cnt_reg - 1'b1;
  wire seq_room = 32'(seq_cnt_reg) < 32'(CORE_WORDS);
  wire seq_inc = exec_ok && hit_osr && seq_room;
  wire wr_ola = exec_wr && hit_ola && (&st);
  wire key_ok = wd == `DRP_OS_KEY;
  wire os_unlock_evt = wr_ola && !key_ok && os_lock_reg && event_catch_reg;

  wire [IW-1:0] mem_idx = hit_osr ? seq_m1[IW-1:0] : a[2 +: IW];
  wire mem_we = exec_wr && (core_grp || (hit_osr && !seq_zero));

  drp_core_mem #(.WORDS(CORE_WORDS), .IW(IW)) u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(mem_we),
    .strb(st),
    .idx(mem_idx),
    .wdata(wd),
    .rdata(mem_rdata)
  );

  // register write effects
  // event catch write
  wire wr_ec = exec_wr && hit_ec && st[0];
  wire wr_rc = exec_wr && hit_rc && st[0];
  wire halt_set = (wr_rc && wd[`DRP_RC_HALT]) || os_unlock_evt;
  wire halt_next = halt_set || (halt_pend_reg && !core_halted);
  // forward only with core powered and debug permitted
  wire halt_allowed = inv_en && (!core_secure || sec_en);
  wire halt_req_next = core_up && halt_allowed && (halt_pend_reg || ext_halt);

  // read data selection
  wire [31:0] rd_direct =
    !ok ? `DRP_ZERO_WORD :
    hit_id ? DEBUG_ID :
    hit_ec ? {31'h0, event_catch_reg} :
    hit_rc ? {31'h0, halt_pend_reg} :
    hit_ols ? {30'h0, os_lock_reg, 1'b1} :
    hit_pwr ? {29'h0, core_halted, halt_req_reg, core_up} :
    (hit_osr && seq_zero) ? 32'(CORE_WORDS) :
    `DRP_ZERO_WORD;
  wire rd_mem = ok && (core_grp || (hit_osr && !seq_zero));
  wire [31:0] rd_final = rd_mem_reg ? mem_rdata : rd_direct_reg;
  wire in_done = state_reg == drp_pkg::ST_DONE;

  // access engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= drp_pkg::ST_IDLE;
      src_reg <= drp_pkg::SRC_COP;
      acc_reg <= '0;
      resp_reg <= `DRP_RESP_OKAY;
      rd_direct_reg <= `DRP_ZERO_WORD;
      rd_mem_reg <= 1'b0;
    end else begin
      case (state_reg)
        drp_pkg::ST_IDLE: begin
          if (take_cop) begin
            src_reg <= drp_pkg::SRC_COP;
            acc_reg <= '{wr: cop_wr, addr: cop_addr, wdata: cop_wdata, strb: 4'hF};
          end else if (take_wr) begin
            src_reg <= drp_pkg::SRC_WR;
            acc_reg <= '{wr: 1'b1, addr: aw_addr_reg, wdata: w_data_reg,
                         strb: w_strb_reg};
          end else if (take_rd) begin
            src_reg <= drp_pkg::SRC_RD;
            acc_reg <= '{wr: 1'b0, addr: ar_addr_reg, wdata: 32'h0, strb: 4'h0};
          end
          if (take_any) begin
            state_reg <= drp_pkg::ST_EXEC;
          end
        end
        drp_pkg::ST_EXEC: begin
          resp_reg <= err_resp;
          rd_direct_reg <= rd_direct;
          rd_mem_reg <= rd_mem && !acc_reg.wr;
          state_reg <= drp_pkg::ST_DONE;
        end
        drp_pkg::ST_DONE: begin
          state_reg <= drp_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= drp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      ar_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      ar_addr_reg <= 12'h000;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      bresp_reg <= `DRP_RESP_OKAY;
      rresp_reg <= `DRP_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (arvalid && arready) begin
        ar_held_reg <= 1'b1;
        ar_addr_reg <= araddr;
      end
      if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rvalid_reg && rready) begin
        rvalid_reg <= 1'b0;
      end
      if (in_done && src_reg == drp_pkg::SRC_WR) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= resp_reg;
      end
      if (in_done && src_reg == drp_pkg::SRC_RD) begin
        ar_held_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rresp_reg <= resp_reg;
        rdata_reg <= rd_final;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cop_ack_reg <= 1'b0;
      cop_err_reg <= 1'b0;
      cop_rdata_reg <= 32'h0000_0000;
    end else begin
      cop_ack_reg <= in_done && src_reg == drp_pkg::SRC_COP;
      if (in_done && src_reg == drp_pkg::SRC_COP) begin
        cop_err_reg <= resp_reg != `DRP_RESP_OKAY;
        cop_rdata_reg <= rd_final;
      end
    end
  end

  // debug-domain state, core power term in the halt_req_reg update and, through the save/restore slave error, in seq_cnt_reg
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_catch_reg <= 1'b0;
      halt_pend_reg <= 1'b0;
      os_lock_reg <= 1'b0;
      seq_cnt_reg <= '0;
      halt_req_reg <= 1'b0;
      restart_reg <= 1'b0;
      clr_sticky_reg <= 1'b0;
    end else begin
      if (wr_ec) begin
        event_catch_reg <= wd[`DRP_EC_OS_UNLOCK];
      end
      halt_pend_reg <= halt_next;
      if (wr_ola) begin
        os_lock_reg <= key_ok;
      end
      if (wr_ola && key_ok) begin
        seq_cnt_reg <= '0;
      end else if (seq_inc) begin
        seq_cnt_reg <= seq_cnt_reg + 1'b1;
      end
      halt_req_reg <= halt_req_next;
      restart_reg <= wr_rc && wd[`DRP_RC_RESTART];
      clr_sticky_reg <= wr_rc && wd[`DRP_RC_CLR_STICKY];
    end
  end

  assign awready = !aw_held_reg;
  assign wready = !w_held_reg;
  assign arready = !ar_held_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign cop_ack = cop_ack_reg;
  assign cop_err = cop_err_reg;
  assign cop_rdata = cop_rdata_reg;
  assign halt_req = halt_req_reg;
  assign restart_req = restart_reg;
  assign clear_sticky_req = clr_sticky_reg;
  assign os_lock = os_lock_reg;

endmodule : drp_top
`default_nettype wire

/* tb/drp_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module drp_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_on,
  input wire logic [1:0] halt_dly,
  input wire logic halt_req,
  input wire logic restart_req,
  output logic core_powered_up,
  output logic core_halted
);
  logic [1:0] cnt_reg;
  assign core_powered_up = power_on;
  always_ff @(posedge aclk) begin
    if (!aresetn || !power_on || restart_req) begin
      cnt_reg <= 2'h0;
      core_halted <= 1'b0;
    end else if (halt_req && !core_halted) begin
      cnt_reg <= cnt_reg + 2'h1;
      core_halted <= (cnt_reg == halt_dly);
    end
  end
endmodule : drp_core_model
`default_nettype wire

/* tb/drp_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module drp_top_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic cop_req,
  input wire logic cop_ack,
  input wire logic core_powered_up,
  input wire logic halt_req,
  input wire logic restart_req
);
  logic [3:0] off_reg;
  logic [3:0] off_next;
  assign off_next = core_powered_up ? 4'h0 : ((off_reg == 4'hF) ? off_reg : off_reg + 4'h1);
  always_ff @(posedge aclk) begin
    if (!aresetn) off_reg <= 4'h0;
    else off_reg <= off_next;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  a_wr_latency: assert property (s_wr_take |=> !bvalid [*2] ##[1:30] bvalid)
    else $error("write answer out of time");
  a_rd_latency: assert property (s_rd_take |=> !rvalid [*2] ##[1:30] rvalid)
    else $error("read answer out of time");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
    else $error("read answer dropped");
  a_aw_busy: assert property (s_wr_take |=> (!awready && !wready) [*2])
    else $error("write slot reopened early");
  a_cop_answer: assert property ($rose(cop_req) |-> ##[3:40] cop_ack)
    else $error("coprocessor answer missing");
  a_cop_pulse: assert property (cop_ack |=> !cop_ack)
    else $error("coprocessor ack too long");
  a_halt_power: assert property (halt_req |-> off_reg < 4'h7)
    else $error("halt request with core off");
  a_restart_pulse: assert property (restart_req |=> !restart_req)
    else $error("restart pulse too long");
endmodule : drp_top_monitor
bind drp_top drp_top_monitor drp_top_monitor_inst (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cop_req, .cop_ack,
  .core_powered_up, .halt_req, .restart_req
);
`default_nettype wire

/* tb/drp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("[FAIL] %0t got %h exp %h", $time, g, e); \
    end \
  end
module drp_top_tb;
  // arbitrary identification value
  localparam logic [31:0] ID = 32'h0000_00A5;
  localparam logic [1:0] OK = 2'h0;
  localparam logic [1:0] SE = 2'h2;
  localparam logic [1:0] DE = 2'h3;
  int tests_run = 0;
  int mismatches = 0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr, cop_addr;
  logic [31:0] wdata, rdata, cop_wdata, cop_rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, halt_dly;
  logic cop_req, cop_wr, cop_ack, cop_err, core_powered_up, external_halt_request;
  logic invasive_debug_enable, secure_invasive_enable, core_secure, core_halted;
  logic halt_req, restart_req, clear_sticky_req, os_lock, power_on, slow;
  logic [7:0] n_restart = 8'h0;
  logic [7:0] n_clear = 8'h0;
  always #20 aclk = ~aclk;
  drp_top #(.DEBUG_ID(ID), .CORE_WORDS(4)) drp_top_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .cop_req, .cop_wr, .cop_addr, .cop_wdata, .cop_ack, .cop_rdata, .cop_err,
    .core_powered_up, .external_halt_request, .invasive_debug_enable,
    .secure_invasive_enable, .core_secure, .core_halted, .halt_req, .restart_req,
    .clear_sticky_req, .os_lock
  );
  drp_core_model drp_core_model_inst (
    .aclk, .aresetn, .power_on, .halt_dly, .halt_req, .restart_req, .core_powered_up,
    .core_halted
  );
  always @(posedge aclk) begin
    if (restart_req) n_restart <= n_restart + 8'h1;
    if (clear_sticky_req) n_clear <= n_clear + 8'h1;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    if (!bready) begin
      bready <= 1'b1;
      @(posedge aclk);
    end
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    if (!rready) begin
      rready <= 1'b1;
      @(posedge aclk);
    end
    rready <= 1'b0;
    `CHK(rresp, er)
    if (er === OK) `CHK(rdata, ed)
  endtask : rd
  task automatic cop(input logic w, input logic [11:0] a, input logic [31:0] ed,
                     input logic ee);
    @(posedge aclk);
    cop_wr <= w;
    cop_addr <= a;
    cop_wdata <= ed;
    cop_req <= 1'b1;
    do @(posedge aclk); while (!cop_ack);
    cop_req <= 1'b0;
    `CHK(cop_err, ee)
    if (!w && !ee) `CHK(cop_rdata, ed)
  endtask : cop
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    finish_test();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, cop_req, cop_wr, power_on} = '0;
    {awaddr, araddr, cop_addr, wdata, cop_wdata} = '0;
    {external_halt_request, core_secure, secure_invasive_enable} = '0;
    wstrb = 4'hF;
    invasive_debug_enable = 1'b1;
    halt_dly = 2'h0;
    slow = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    // core off
    rd(12'h000, ID, OK);
    wr(12'h020, 32'h1, DE);
    slow <= 1'b0;
    wr(12'h100, 32'h1, SE);
    rd(12'h100, 32'h0, SE);
    wr(12'h004, 32'h1, OK);
    core_secure <= 1'b1;
    wr(12'h008, 32'h1, OK);
    rd(12'h008, 32'h1, OK);
    `CHK(halt_req, 1'b0)
    wr(12'h00C, 32'hC5ACCE55, OK);
    rd(12'h010, 32'h3, OK);
    `CHK(os_lock, 1'b1)
    wr(12'h014, 32'h0, SE);
    rd(12'h018, 32'h0, OK);
    // power up, halt blocked by secure state
    power_on <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(12'h008, 32'h1, OK);
    `CHK(halt_req, 1'b0)
    rd(12'h004, 32'h1, OK);
    secure_invasive_enable <= 1'b1;
    repeat (12) @(posedge aclk);
    rd(12'h018, 32'h5, OK);
    rd(12'h008, 32'h0, OK);
    wr(12'h008, 32'h6, OK);
    `CHK(n_restart, 8'h1)
    `CHK(n_clear, 8'h1)
    wr(12'h100, 32'hA5A5_0001, OK);
    cop(1'b1, 12'h104, 32'h1234_5678, 1'b0);
    cop(1'b0, 12'h104, 32'h1234_5678, 1'b0);
    cop(1'b0, 12'h020, 32'h0, 1'b1);
    rd(12'h014, 32'h4, OK);
    rd(12'h014, 32'hA5A5_0001, OK);
    wr(12'h00C, 32'hC5ACCE55, OK);
    rd(12'h014, 32'h4, OK);
    // unlock with catch armed, slow core
    halt_dly <= 2'h3;
    wr(12'h00C, 32'h0, OK);
    `CHK(os_lock, 1'b0)
    repeat (14) @(posedge aclk);
    rd(12'h018, 32'h5, OK);
    // core off again
    power_on <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(12'h004, 32'h1, OK);
    rd(12'h100, 32'h0, SE);
    cop(1'b0, 12'h104, 32'h0, 1'b1);
    // external halt held while core off, then powered
    external_halt_request <= 1'b1;
    repeat (10) @(posedge aclk);
    `CHK(halt_req, 1'b0)
    power_on <= 1'b1;
    repeat (10) @(posedge aclk);
    `CHK(halt_req, 1'b1)
    // system drops invasive enable first
    invasive_debug_enable <= 1'b0;
    repeat (10) @(posedge aclk);
    `CHK(halt_req, 1'b0)
    invasive_debug_enable <= 1'b1;
    repeat (10) @(posedge aclk);
    `CHK(halt_req, 1'b1)
    power_on <= 1'b0;
    repeat (10) @(posedge aclk);
    `CHK(halt_req, 1'b0)
    finish_test();
  end
endmodule : drp_top_tb
`default_nettype wire
